// [common/ebf_consts.svh]
// Constants for the external bus fault, retry and arbitration controller.
// Assumes inclusion by the package and by the controller only.
`ifndef EBF_CONSTS_SVH
`define EBF_CONSTS_SVH

`define EBF_ADDR_W 24
`define EBF_DATA_W 16
`define EBF_FC_W 3
`define EBF_SIZ_W 2
`define EBF_CNT_W 2
`define EBF_NPIN 5
`define EBF_PRECHARGE 16'hFFFF
`define EBF_RETRY_SYNC_CLK 2
`define EBF_GRANT_HOLD_CLK 2
`define EBF_P_ACK 0
`define EBF_P_FAULT 1
`define EBF_P_STOP 2
`define EBF_P_BREQ 3
`define EBF_P_GACK 4

`endif

// [common/ebf_pkg.sv]
// Types shared by the external bus fault, retry and arbitration controller.
// Assumes ebf_consts.svh is on the include path.
`default_nettype none
package ebf_pkg;
`include "ebf_consts.svh"

	// One external cycle as the core presents it
	typedef struct packed {
		logic [`EBF_ADDR_W-1:0] addr;
		logic [`EBF_FC_W-1:0] fc;
		logic [`EBF_SIZ_W-1:0] siz;
		logic rw;
		logic [`EBF_DATA_W-1:0] wdata;
		logic operand_end;
	} bus_cycle_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_TAIL,
		ST_STOPPED,
		ST_RETRY_WAIT,
		ST_RETRY_SYNC
	} bus_state_t;

	typedef enum logic [1:0] {
		AR_IDLE,
		AR_GRANT,
		AR_OWNED
	} arb_state_t;

	// Whole controller state
	typedef struct packed {
		logic [`EBF_NPIN-1:0] s1;
		logic [`EBF_NPIN-1:0] s2;
		logic [`EBF_NPIN-1:0] s3;
		logic [`EBF_NPIN-1:0] pin;
		bus_state_t bst;
		arb_state_t ast;
		bus_cycle_t cyc;
		logic [`EBF_CNT_W-1:0] cnt;
		logic [`EBF_CNT_W-1:0] gcnt;
		logic strobe_n;
		logic data_oe;
		logic lock_n;
		logic bg_n;
		logic done;
		logic fault_ret;
		logic [`EBF_DATA_W-1:0] rdata;
		logic flt_latch;
		logic in_exc;
		logic reset_done;
		logic dbl;
		logic retry_arb;
		logic op_end;
	} ctl_state_t;
endpackage
`default_nettype wire

// [hdl/ext_bus_fault_ctrl.sv]
// External bus termination, fault, retry, halt and arbitration control.
// Assumes a core that holds cycle requests until taken and pulses its
// instruction and exception events on i_clock; bus pins are asynchronous.
`default_nettype none
`include "ebf_consts.svh"

module ext_bus_fault_ctrl
	import ebf_pkg::*;
#(
	parameter int RETRY_SYNC_CLK = `EBF_RETRY_SYNC_CLK,
	parameter int GRANT_HOLD_CLK = `EBF_GRANT_HOLD_CLK
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Core cycle request and answer
	input wire logic i_cycle_valid,
	input wire bus_cycle_t i_cycle,
	input wire logic i_locked_seq,
	output logic o_cycle_ready,
	output logic o_cycle_done,
	output logic o_cycle_fault,
	output logic [`EBF_DATA_W-1:0] o_rdata,
	// Core exception events
	input wire logic i_monitor_fault,
	input wire logic i_exc_begin,
	input wire logic i_insn_exec,
	input wire logic i_frame_restore,
	output logic o_fault_pending,
	output logic o_double_halt,
	output logic o_irq_block,
	// Termination and arbitration pins
	input wire logic i_transfer_acknowledge_n,
	input wire logic i_bus_fault_input_n,
	input wire logic i_stop_request_n,
	input wire logic i_bus_request_n,
	input wire logic i_grant_acknowledge_n,
	output logic o_stop_request_out_n,
	output logic o_stop_request_oe,
	output logic o_bus_grant_n,
	// Address, control and data pins
	input wire logic [`EBF_DATA_W-1:0] i_data_in,
	output logic [`EBF_DATA_W-1:0] o_data_out,
	output logic o_data_oe,
	output logic [`EBF_ADDR_W-1:0] o_addr,
	output logic [`EBF_FC_W-1:0] o_fc,
	output logic [`EBF_SIZ_W-1:0] o_siz,
	output logic o_rw,
	output logic o_address_strobe_n,
	output logic o_data_strobe_n,
	output logic o_locked_cycle_indicator_n,
	output logic o_ctrl_oe
);

	// Counters are two bits wide, so loads above three cannot be held
	if (RETRY_SYNC_CLK < 1 || RETRY_SYNC_CLK > 4 || GRANT_HOLD_CLK < 1 ||
		GRANT_HOLD_CLK > 4) begin
		$error("ext_bus_fault_ctrl: counts must lie in 1..4");
	end

	localparam logic [`EBF_CNT_W-1:0] RETRY_LOAD = `EBF_CNT_W'(RETRY_SYNC_CLK - 1);
	localparam logic [`EBF_CNT_W-1:0] GRANT_LOAD = `EBF_CNT_W'(GRANT_HOLD_CLK - 1);

	logic [1:0] rst_pipe_q;
	logic rst_sync_n;
	ctl_state_t q;
	ctl_state_t d;
	logic ack;
	logic flt;
	logic stp;
	logic brq;
	logic gack;
	logic fault_ev;
	logic dbl_cond;
	logic grant_ok;
	logic first_insn;

	// Reset release
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_q[1];

	// Filtered pin levels, active high
	assign ack = q.pin[`EBF_P_ACK];
	assign flt = q.pin[`EBF_P_FAULT] | i_monitor_fault;
	assign stp = q.pin[`EBF_P_STOP];
	assign brq = q.pin[`EBF_P_BREQ];
	assign gack = q.pin[`EBF_P_GACK];

	// Fault that ends a cycle as an exception
	assign fault_ev = (q.bst == ST_RUN) && flt && !stp;
	assign dbl_cond = q.in_exc | ~q.reset_done | i_frame_restore;
	assign first_insn = i_insn_exec & q.in_exc;

	// Points where the bus may be handed over
	assign grant_ok = q.lock_n && ((q.bst == ST_IDLE && q.op_end) ||
		q.bst == ST_STOPPED || (q.bst == ST_RETRY_WAIT && q.retry_arb));

	// New cycles only with the bus ours, lowest priority
	assign o_cycle_ready = (q.bst == ST_IDLE) && !q.dbl && !stp && (q.ast == AR_IDLE) &&
		!(brq && grant_ok);

	always_comb begin
		d = q;
		d.done = 1'b0;
		// Three-stage pin synchroniser, change taken once stages two and three agree
		d.s1 = ~{i_grant_acknowledge_n, i_bus_request_n, i_stop_request_n,
			i_bus_fault_input_n, i_transfer_acknowledge_n};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.pin = (q.s3 & ~(q.s2 ^ q.s3)) | (q.pin & (q.s2 ^ q.s3));

		case (q.bst)
			ST_IDLE: begin
				if (q.ast == AR_IDLE) begin
					d.lock_n = ~i_locked_seq;
				end
				if (i_cycle_valid && o_cycle_ready) begin
					d.cyc = i_cycle;
					d.bst = ST_RUN;
					d.strobe_n = 1'b0;
					d.data_oe = ~i_cycle.rw;
					d.op_end = 1'b0;
				end
			end
			ST_RUN: begin
				if (flt && stp) begin
					d.strobe_n = 1'b1;
					d.data_oe = 1'b0;
					d.retry_arb = brq & q.lock_n;
					d.bst = ST_RETRY_WAIT;
				end else if (flt) begin
					d.strobe_n = 1'b1;
					d.data_oe = 1'b0;
					d.done = 1'b1;
					d.fault_ret = 1'b1;
					d.rdata = `EBF_PRECHARGE;
					d.op_end = 1'b1;
					d.bst = ST_TAIL;
				end else if (ack) begin
					d.strobe_n = 1'b1;
					d.data_oe = 1'b0;
					d.done = 1'b1;
					d.fault_ret = 1'b0;
					d.rdata = q.cyc.rw ? i_data_in : q.rdata;
					d.op_end = q.cyc.operand_end;
					d.bst = ST_TAIL;
				end
			end
			ST_TAIL: begin
				if (!ack && !flt) begin
					d.bst = stp ? ST_STOPPED : ST_IDLE;
				end
			end
			ST_STOPPED: begin
				if (!stp) begin
					d.bst = ST_IDLE;
				end
			end
			ST_RETRY_WAIT: begin
				if (!flt && !stp && q.ast == AR_IDLE && !(q.retry_arb && brq)) begin
					d.cnt = RETRY_LOAD;
					d.retry_arb = 1'b0;
					d.bst = ST_RETRY_SYNC;
				end
			end
			ST_RETRY_SYNC: begin
				if (q.cnt == '0) begin
					d.strobe_n = 1'b0;
					d.data_oe = ~q.cyc.rw;
					d.bst = ST_RUN;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			default: begin
				d.bst = ST_IDLE;
			end
		endcase

		// Fault latch and double fault; a fault in the clearing cycle sets the double fault, not the latch
		if (i_insn_exec) begin
			d.reset_done = 1'b1;
		end
		if (first_insn) begin
			d.flt_latch = 1'b0;
			d.in_exc = 1'b0;
		end
		if (i_exc_begin) begin
			d.in_exc = 1'b1;
		end
		if (fault_ev) begin
			if (dbl_cond) begin
				d.dbl = 1'b1;
			end else begin
				d.flt_latch = 1'b1;
			end
		end

		// Arbitration, device lowest priority at the handover points
		case (q.ast)
			AR_IDLE: begin
				if (brq && grant_ok) begin
					d.bg_n = 1'b0;
					d.ast = AR_GRANT;
				end
			end
			AR_GRANT: begin
				if (gack) begin
					d.gcnt = GRANT_LOAD;
					d.ast = AR_OWNED;
				end else if (!brq) begin
					d.bg_n = 1'b1;
					d.ast = AR_IDLE;
				end
			end
			AR_OWNED: begin
				if (q.gcnt != '0) begin
					d.gcnt = q.gcnt - 1'b1;
				end else begin
					d.bg_n = ~brq;
				end
				if (!gack) begin
					d.ast = (q.gcnt == '0 && brq) ? AR_GRANT : AR_IDLE;
					d.bg_n = ~(q.gcnt == '0 && brq);
				end
			end
			default: begin
				d.ast = AR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			q <= '0;
			q.strobe_n <= 1'b1;
			q.lock_n <= 1'b1;
			q.bg_n <= 1'b1;
			q.op_end <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Core side
	assign o_cycle_done = q.done;
	assign o_cycle_fault = q.fault_ret;
	assign o_rdata = q.rdata;
	assign o_fault_pending = q.flt_latch;
	assign o_double_halt = q.dbl;
	assign o_irq_block = stp | q.dbl;

	// Pins; address, control and data released while an outside master owns the bus
	assign o_ctrl_oe = (q.ast != AR_OWNED);
	assign o_addr = q.cyc.addr;
	assign o_fc = q.cyc.fc;
	assign o_siz = q.cyc.siz;
	assign o_rw = q.cyc.rw;
	assign o_address_strobe_n = q.strobe_n;
	assign o_data_strobe_n = q.strobe_n;
	assign o_data_out = q.cyc.wdata;
	assign o_data_oe = q.data_oe & o_ctrl_oe;
	assign o_locked_cycle_indicator_n = q.lock_n;
	assign o_bus_grant_n = q.bg_n;
	assign o_stop_request_out_n = 1'b0;
	assign o_stop_request_oe = q.dbl;

	// Checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!rst_sync_n);

	sequence retry_term_s;
		q.bst == ST_RUN && flt && stp;
	endsequence

	sequence retry_sync_s;
		q.bst == ST_RETRY_WAIT ##1 q.bst == ST_RETRY_SYNC;
	endsequence

	a_fault_latched: assert property (fault_ev && !dbl_cond |=> q.flt_latch)
		else $error("Fault not latched at cycle end");
	a_fault_precharge: assert property (q.done && q.fault_ret |-> q.rdata == `EBF_PRECHARGE)
		else $error("Faulted cycle returned data other than precharge");
	a_latch_clear: assert property (first_insn && !fault_ev |=> !q.flt_latch)
		else $error("Fault latch not cleared by handler entry");
	a_double_halt_hold: assert property (q.dbl |=> q.dbl && o_stop_request_oe && !o_cycle_ready)
		else $error("Double fault halt not held");
	a_retry_strobes: assert property (retry_term_s |=> q.strobe_n && !q.done [*2])
		else $error("Retry did not idle strobes");
	a_retry_delay: assert property (retry_sync_s |-> ##RETRY_SYNC_CLK q.bst == ST_RUN && !q.strobe_n)
		else $error("Retry restart delay wrong");
	a_retry_same_cycle: assert property (q.bst == ST_RETRY_WAIT |=> $stable(q.cyc))
		else $error("Retried cycle changed");
	a_grant_unlocked: assert property ($fell(q.bg_n) |-> q.lock_n)
		else $error("Grant asserted while locked");
	a_owned_release: assert property (q.ast == AR_OWNED |-> !o_ctrl_oe && !o_data_oe)
		else $error("Outputs driven while bus granted away");
	a_normal_end: assert property (q.bst == ST_RUN && ack && !flt && !stp |=> q.done && !q.fault_ret)
		else $error("Normal termination not reported");
	a_stop_holds: assert property (q.bst == ST_STOPPED |-> q.strobe_n && !o_data_oe)
		else $error("Strobes or data active while stopped");

endmodule
`default_nettype wire

// [tb/ebf_far_end.sv]
// Far-end model: one slave answering strobes and one external master.
// Assumes the bench drives i_mode and i_want shortly after the clock edge.
`default_nettype none
module ebf_far_end #(
	parameter logic [15:0] DATA = 16'hA5C3
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Device side
	input wire logic i_strobe_n,
	input wire logic i_rw,
	input wire logic i_bus_grant_n,
	// Bench control
	input wire logic [1:0] i_mode,
	input wire logic i_want,
	// Pins toward the device
	output logic o_ack_n,
	output logic o_fault_n,
	output logic o_stop_n,
	output logic o_breq_n,
	output logic o_gack_n,
	output logic [15:0] o_data,
	output logic [3:0] o_starts
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] age;
	logic [2:0] hold;
	logic shot;
	// Undriven data shows the inverse pattern
	assign o_data = (!i_strobe_n && i_rw) ? DATA : ~DATA;
	// Slave: answers two cycles into a strobe, on the rising edge
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{o_ack_n, o_fault_n, o_stop_n} <= 3'h7;
			{age, shot, o_starts} <= '0;
		end else if (i_strobe_n) begin
			{o_ack_n, o_fault_n, o_stop_n} <= 3'h7;
			age <= 3'h0;
			if (i_mode == 2'h0) shot <= 1'b0;
		end else begin
			if (age != 3'h7) age <= age + 3'h1;
			if (age == 3'h0) o_starts <= o_starts + 4'h1;
			if (age == 3'h2) begin
				if (i_mode == 2'h1) o_fault_n <= 1'b0;
				else if (i_mode == 2'h2 && !shot) begin
					{o_fault_n, o_stop_n, shot} <= 3'h1;
				end else o_ack_n <= 1'b0;
			end
		end
	end
	// Master: takes the bus on grant with acknowledge idle
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{o_breq_n, o_gack_n, hold} <= 5'h18;
		end else if (!o_gack_n) begin
			hold <= hold + 3'h1;
			if (hold == 3'h7) o_gack_n <= 1'b1;
		end else if (!i_bus_grant_n && !o_breq_n) begin
			{o_gack_n, o_breq_n, hold} <= 5'h08;
		end else o_breq_n <= ~i_want;
	end
endmodule
`default_nettype wire

// [tb/ext_bus_fault_ctrl_bench.sv]
// Bench for the external bus fault, retry and arbitration controller.
// Assumes ebf_pkg and ebf_far_end are compiled first.
`default_nettype none
module ext_bus_fault_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, exc = 1'b0, insn = 1'b0;
	logic want = 1'b0, mon = 1'b0, lock = 1'b0, frs = 1'b0, hold_n = 1'b1;
	logic [1:0] mode = 2'h0;
	ebf_pkg::bus_cycle_t cyc = '0;
	logic ready, done, cflt, pend, dbl, irqb, ack_n, flt_n, pstop_n, stop_n, breq_n, gack_n;
	logic sto_n, sto_oe, bg_n, doe, ctl_oe, as_n, ds_n, lk_n, rw;
	logic [15:0] rdata, din, dout;
	logic [23:0] addr;
	logic [2:0] fc;
	logic [1:0] siz;
	logic [3:0] starts;
	logic [1:0] watch;
	int bad_count = 0, n_tests = 0, ticks = 0;
	assign stop_n = pstop_n & hold_n & (~sto_oe | sto_n);
	assign watch = {ctl_oe, bg_n};
	ext_bus_fault_ctrl dut_u (.i_clock(clk), .i_rst_n(rst_n), .i_cycle_valid(valid),
		.i_cycle(cyc), .i_locked_seq(lock), .o_cycle_ready(ready), .o_cycle_done(done),
		.o_cycle_fault(cflt), .o_rdata(rdata), .i_monitor_fault(mon), .i_exc_begin(exc),
		.i_insn_exec(insn), .i_frame_restore(frs), .o_fault_pending(pend),
		.o_double_halt(dbl), .o_irq_block(irqb), .i_transfer_acknowledge_n(ack_n),
		.i_bus_fault_input_n(flt_n), .i_stop_request_n(stop_n), .i_bus_request_n(breq_n),
		.i_grant_acknowledge_n(gack_n), .o_stop_request_out_n(sto_n),
		.o_stop_request_oe(sto_oe), .o_bus_grant_n(bg_n), .i_data_in(din),
		.o_data_out(dout), .o_data_oe(doe), .o_addr(addr), .o_fc(fc), .o_siz(siz),
		.o_rw(rw), .o_address_strobe_n(as_n), .o_data_strobe_n(ds_n),
		.o_locked_cycle_indicator_n(lk_n), .o_ctrl_oe(ctl_oe));
	ebf_far_end far_u (.i_clock(clk), .i_rst_n(rst_n), .i_strobe_n(as_n), .i_rw(rw),
		.i_bus_grant_n(bg_n), .i_mode(mode), .i_want(want), .o_ack_n(ack_n),
		.o_fault_n(flt_n), .o_stop_n(pstop_n), .o_breq_n(breq_n), .o_gack_n(gack_n),
		.o_data(din), .o_starts(starts));
	task automatic stop_test();
		if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic ev(input logic e);
		if (e) exc = 1'b1;
		else insn = 1'b1;
		tick();
		exc = 1'b0;
		insn = 1'b0;
		tick();
	endtask
	task automatic wt(input int i, input logic v);
		int n;
		for (n = 0; n < 60 && watch[i] !== v; n++) tick();
		chk(24'(watch[i]), 24'(v));
	endtask
	task automatic run(input logic r, input logic [23:0] a, output logic f,
		output logic [15:0] rd);
		int n;
		n = 0;
		cyc = '{addr: a, fc: 3'h5, siz: 2'h2, rw: r, wdata: a[15:0], operand_end: 1'b1};
		valid = 1'b1;
		while (ready !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		tick();
		valid = 1'b0;
		while (done !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		chk(24'(n < 300), 24'h1);
		f = cflt;
		rd = rdata;
	endtask
	task automatic s_norm();
		logic f;
		logic [15:0] rd;
		ev(1'b0);
		run(1'b0, 24'h000100, f, rd);
		chk(24'(f), 24'h0);
		run(1'b1, 24'h000102, f, rd);
		chk(24'(rd), 24'h00A5C3);
	endtask
	task automatic s_fault();
		logic f;
		logic [15:0] rd;
		mode = 2'h1;
		run(1'b1, 24'h000200, f, rd);
		mode = 2'h0;
		chk(24'(f), 24'h1);
		chk(24'(rd), 24'h00FFFF);
		tick();
		chk(24'(pend), 24'h1);
		chk(24'(dbl), 24'h0);
		ev(1'b1);
		ev(1'b0);
		chk(24'(pend), 24'h0);
		mode = 2'h1;
		run(1'b1, 24'h000204, f, rd);
		mode = 2'h0;
		tick();
		chk(24'(dbl), 24'h0);
		ev(1'b1);
		ev(1'b0);
	endtask
	task automatic s_retry();
		logic f;
		logic [15:0] rd;
		logic [3:0] s0;
		s0 = starts;
		mode = 2'h2;
		run(1'b0, 24'h00ABCD, f, rd);
		mode = 2'h0;
		chk(24'(f), 24'h0);
		chk(24'(starts - s0), 24'h2);
		chk(addr, 24'h00ABCD);
		chk(24'(pend), 24'h0);
		chk(24'(dout), 24'h00ABCD);
		chk(24'({fc, siz, rw}), 24'h00002C);
	endtask
	task automatic s_arb();
		want = 1'b1;
		wt(0, 1'b0);
		wt(1, 1'b0);
		want = 1'b0;
		wt(0, 1'b1);
		wt(1, 1'b1);
	endtask
	task automatic s_dbl();
		logic f;
		logic [15:0] rd;
		ev(1'b1);
		mode = 2'h1;
		run(1'b1, 24'h000300, f, rd);
		mode = 2'h0;
		tick();
		chk(24'(dbl), 24'h1);
		chk(24'(sto_oe), 24'h1);
		tick();
		chk(24'(irqb), 24'h1);
		s_arb();
	endtask
	task automatic s_halt();
		logic f;
		logic [15:0] rd;
		hold_n = 1'b0;
		run(1'b0, 24'h000400, f, rd);
		chk(24'(f), 24'h0);
		repeat (8) tick();
		chk(24'(ready), 24'h0);
		chk(24'(irqb), 24'h1);
		chk(24'({as_n, ds_n, doe}), 24'h6);
		chk(addr, 24'h000400);
		hold_n = 1'b1;
		run(1'b0, 24'h000402, f, rd);
		chk(24'(f), 24'h0);
	endtask
	task automatic s_lock();
		logic f;
		logic [15:0] rd;
		lock = 1'b1;
		repeat (8) tick();
		mode = 2'h1;
		want = 1'b1;
		run(1'b1, 24'h000500, f, rd);
		mode = 2'h0;
		chk(24'(f), 24'h1);
		repeat (8) tick();
		chk(24'(bg_n), 24'h1);
		chk(24'(lk_n), 24'h0);
		lock = 1'b0;
		s_arb();
	endtask
	task automatic s_reset();
		logic f;
		logic [15:0] rd;
		rst_n = 1'b0;
		repeat (4) tick();
		chk(24'({dbl, sto_oe, bg_n, ctl_oe}), 24'h3);
		rst_n = 1'b1;
		repeat (3) tick();
		ev(1'b0);
		frs = 1'b1;
		mon = 1'b1;
		run(1'b1, 24'h000600, f, rd);
		frs = 1'b0;
		mon = 1'b0;
		chk(24'({f, dbl}), 24'h3);
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) tick();
		s_norm();
		s_fault();
		s_retry();
		s_arb();
		s_halt();
		s_lock();
		s_dbl();
		s_reset();
		stop_test();
	end
endmodule
`default_nettype wire
